//--- design/pdo_slave.sv
// Process data slave: frame decode, telemetry reply, register slave
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/100ps
module pdo_slave #(
  parameter int TLM_REGS    = pdo_slave_pkg::TLM_REGS_DEF,
  parameter int REPLY_LIMIT = pdo_slave_pkg::REPLY_LIMIT_CYC
) (
  input  wire logic                         CLK,
  input  wire logic                         SYS_RST,
  input  wire logic [6:0]                   NODE_ID,
  input  wire logic                         WB_CYC,
  input  wire logic                         WB_STB,
  input  wire logic                         WB_WE,
  input  wire logic [7:0]                   WB_ADR,
  input  wire logic [3:0]                   WB_SEL,
  input  wire logic [31:0]                  WB_DAT_I,
  output logic      [31:0]                  WB_DAT_O,
  output logic                              WB_ACK,
  input  wire logic                         RX_VALID,
  input  wire pdo_slave_pkg::can_frame_type RX_FRAME,
  input  wire logic                         TX_READY,
  output logic                              TX_VALID,
  output pdo_slave_pkg::can_frame_type      TX_FRAME,
  output logic                              CMD_VALID,
  output pdo_slave_pkg::command_type        CMD
);
  import pdo_slave_pkg::*;

  localparam int         IDX_W  = $clog2(TLM_REGS);
  localparam int         WAIT_W = $clog2(REPLY_LIMIT + 1);
  localparam logic [8:0] REG_LIMIT = 9'(TLM_REGS);
  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(REPLY_LIMIT - 1);

  // Register map from 40h has room for 48 telemetry words; 32 is the largest power of two allowed
  if (TLM_REGS < 2 || TLM_REGS > 32 || (1 << IDX_W) != TLM_REGS) begin : g_bad_regs
    $error("TLM_REGS must be a power of two from 2 to 32");
  end
  if (REPLY_LIMIT < 1) begin : g_bad_limit
    $error("REPLY_LIMIT must be at least one cycle");
  end

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_type;

  // Identifier of a channel: base plus 100h per channel plus node
  function automatic logic [10:0] cob_id(input logic [10:0] base,
                                         input logic [1:0]  ch,
                                         input logic [6:0]  node);
    cob_id = base + {1'b0, ch, 8'h00} + {4'h0, node};
  endfunction

  logic [6:0]        node_meta;
  logic [6:0]        node_id;
  logic              oper;
  logic              next_oper;
  logic [15:0]       sync_sel;
  logic [15:0]       next_sync_sel;
  logic              next_ack;
  logic [31:0]       next_rdata;
  logic              tlm_we;
  logic [IDX_W-1:0]  tlm_widx;
  logic [5:0]        tlm_word;
  logic              tlm_in_map;
  logic [7:0]        reg_adr;
  logic [15:0]       tlm [TLM_REGS];
  logic              rx_hit;
  logic [1:0]        rx_chan;
  logic [7:0]        rx_code;
  logic              rx_own;
  logic              rx_sync;
  logic              rx_tlm;
  logic              rx_cmd;
  logic              rx_unknown;
  tx_state_type      tx_state;
  tx_state_type      next_tx_state;
  logic              next_tx_valid;
  can_frame_type     next_tx_frame;
  logic [WAIT_W-1:0] wait_cnt;
  logic [WAIT_W-1:0] next_wait;
  logic [7:0]        unk_cnt;
  logic [7:0]        next_unk;
  logic [7:0]        miss_cnt;
  logic [7:0]        next_miss;
  logic [1:0]        pick_ch;
  logic [7:0]        pick_a;
  logic [7:0]        pick_b;
  logic              next_cmd_valid;
  command_type       next_cmd;

  // Node address comes from straps off this clock domain
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      node_meta <= 7'h00;
      node_id   <= 7'h00;
    end else begin
      node_meta <= NODE_ID;
      node_id   <= node_meta;
    end
  end

  // Frame decode; node control frames (id 000h) never match
  always_comb begin
    rx_hit  = 1'b0;
    rx_chan = 2'd0;
    for (int k = 0; k < 4; k++) begin
      if (RX_FRAME.id == cob_id(RX_BASE, 2'(k), node_id)) begin
        rx_hit  = 1'b1;
        rx_chan = 2'(k);
      end
    end
    rx_code = RX_FRAME.data[7:0];
    rx_sync = RX_VALID && (RX_FRAME.id == SYNC_ID);
    rx_own  = RX_VALID && rx_hit && (RX_FRAME.dlc != 4'h0);
    rx_tlm  = rx_own && (rx_code == CODE_TLM) &&
              ({1'b0, RX_FRAME.data[15:8]} < REG_LIMIT) &&
              ({1'b0, RX_FRAME.data[23:16]} < REG_LIMIT);
    rx_cmd  = rx_own && (rx_code >= CODE_CMD_LO) &&
              (rx_code <= CODE_CMD_HI);
    rx_unknown = rx_own && !rx_tlm && !rx_cmd;
  end

  // Command hand-off; nothing is queued for transmission
  always_comb begin
    next_cmd_valid = rx_cmd;
    next_cmd       = CMD;
    if (rx_cmd) begin
      next_cmd = {rx_chan, rx_code, RX_FRAME.data[63:8]};
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      CMD_VALID <= 1'b0;
      CMD       <= '0;
    end else begin
      CMD_VALID <= next_cmd_valid;
      CMD       <= next_cmd;
    end
  end

  // Transmit side: a reply starts only from a received trigger
  always_comb begin
    next_tx_state = tx_state;
    next_tx_valid = TX_VALID;
    next_tx_frame = TX_FRAME;
    next_wait     = wait_cnt;
    next_unk      = unk_cnt;
    next_miss     = miss_cnt;
    pick_ch       = rx_tlm ? rx_chan : 2'd0;
    pick_a        = rx_tlm ? RX_FRAME.data[15:8] : sync_sel[7:0];
    pick_b        = rx_tlm ? RX_FRAME.data[23:16] : sync_sel[15:8];
    if (rx_unknown) begin
      next_unk = unk_cnt + 8'h01;
    end
    case (tx_state)
      TX_IDLE: begin
        // Sent at once: no inhibit gap, no event timer
        if (oper && (rx_tlm || rx_sync)) begin
          next_tx_state      = TX_SEND;
          next_tx_valid      = 1'b1;
          next_wait          = '0;
          next_tx_frame.id   = cob_id(TX_BASE, pick_ch, node_id);
          next_tx_frame.dlc  = TLM_DLC;
          next_tx_frame.data = {16'h0000,
                                tlm[pick_b[IDX_W-1:0]],
                                tlm[pick_a[IDX_W-1:0]],
                                pick_b, pick_a};
        end
      end
      TX_SEND: begin
        if (rx_tlm || rx_sync) begin
          next_miss = miss_cnt + 8'h01;
        end
        if (!oper) begin
          next_tx_state = TX_IDLE;
          next_tx_valid = 1'b0;
        end else if (TX_READY) begin
          next_tx_state = TX_IDLE;
          next_tx_valid = 1'b0;
        end else if (wait_cnt == WAIT_LAST) begin
          // A stale answer is worse than none: withdraw it
          next_tx_state = TX_IDLE;
          next_tx_valid = 1'b0;
          next_miss     = miss_cnt + 8'h01;
        end else begin
          next_wait = wait_cnt + WAIT_W'(1);
        end
      end
      default: begin
        next_tx_state = TX_IDLE;
        next_tx_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tx_state <= TX_IDLE;
      TX_VALID <= 1'b0;
      TX_FRAME <= '0;
      wait_cnt <= '0;
      unk_cnt  <= 8'h00;
      miss_cnt <= 8'h00;
    end else begin
      tx_state <= next_tx_state;
      TX_VALID <= next_tx_valid;
      TX_FRAME <= next_tx_frame;
      wait_cnt <= next_wait;
      unk_cnt  <= next_unk;
      miss_cnt <= next_miss;
    end
  end

  // Register slave: one wait state, ack drops after one cycle
  always_comb begin
    reg_adr       = {WB_ADR[7:2], 2'b00};
    next_ack      = WB_CYC && WB_STB && !WB_ACK;
    tlm_word      = 6'(WB_ADR[7:2] - 6'h10);
    tlm_in_map    = (reg_adr >= ADR_TLM) && ({3'b000, tlm_word} < REG_LIMIT);
    tlm_widx      = tlm_word[IDX_W-1:0];
    tlm_we        = next_ack && WB_WE && tlm_in_map;
    next_oper     = oper;
    next_sync_sel = sync_sel;
    next_rdata    = 32'h0000_0000;
    if (next_ack && WB_WE) begin
      // Records have no write path: they are read-only
      if (reg_adr == ADR_CTRL && WB_SEL[0]) begin
        next_oper = WB_DAT_I[0];
      end
      if (reg_adr == ADR_SYNC_SEL && WB_SEL[0]) begin
        next_sync_sel[7:0] = WB_DAT_I[7:0];
      end
      if (reg_adr == ADR_SYNC_SEL && WB_SEL[1]) begin
        next_sync_sel[15:8] = WB_DAT_I[15:8];
      end
    end
    if (next_ack && !WB_WE) begin
      if (reg_adr == ADR_CTRL) begin
        next_rdata = {31'h0, oper};
      end else if (reg_adr == ADR_STATUS) begin
        next_rdata = {17'h0, node_id, 6'h00, TX_VALID, oper};
      end else if (reg_adr == ADR_SYNC_SEL) begin
        next_rdata = {16'h0000, sync_sel};
      end else if (reg_adr == ADR_DROPS) begin
        next_rdata = {16'h0000, miss_cnt, unk_cnt};
      end else if (reg_adr == ADR_LAST_CMD) begin
        next_rdata = {22'h0, CMD.chan, CMD.code};
      end else if (reg_adr[7:4] == ADR_RX_REC[7:4]) begin
        next_rdata = {5'h00, cob_id(RX_BASE, WB_ADR[3:2], node_id),
                      TRANS_TYPE, ENTRY_COUNT};
      end else if (reg_adr[7:4] == ADR_TX_REC[7:4]) begin
        next_rdata = {5'h00, cob_id(TX_BASE, WB_ADR[3:2], node_id),
                      TRANS_TYPE, ENTRY_COUNT};
      end else if (tlm_in_map) begin
        next_rdata = {16'h0000, tlm[tlm_widx]};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      WB_ACK   <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      oper     <= CTRL_RESET;
      sync_sel <= SYNC_SEL_RESET;
    end else begin
      WB_ACK   <= next_ack;
      WB_DAT_O <= next_rdata;
      oper     <= next_oper;
      sync_sel <= next_sync_sel;
    end
  end

  // Telemetry words; contents need no reset
  always_ff @(posedge CLK) begin
    if (tlm_we && WB_SEL[0]) begin
      tlm[tlm_widx][7:0] <= WB_DAT_I[7:0];
    end
    if (tlm_we && WB_SEL[1]) begin
      tlm[tlm_widx][15:8] <= WB_DAT_I[15:8];
    end
  end

  // Checks on the block's own outputs
  default clocking chk_clk @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_rec_read;
    WB_CYC && WB_STB && !WB_WE && !WB_ACK && WB_ADR[7:5] == 3'b001;
  endsequence
  sequence s_rec_answer;
    WB_ACK && WB_DAT_O[15:8] == TRANS_TYPE && WB_DAT_O[7:0] == ENTRY_COUNT;
  endsequence
  sequence s_sync_start;
    oper && rx_sync && !TX_VALID;
  endsequence
  sequence s_sync_frame;
    TX_VALID && TX_FRAME.id[10:7] == 4'h3 && TX_FRAME.dlc == TLM_DLC;
  endsequence

  chk_rec_fixed: assert property (s_rec_read |=> s_rec_answer)
    else $error("parameter record read is wrong");
  chk_preop_silent: assert property (!oper |=> !TX_VALID)
    else $error("frame offered while pre-operational");
  chk_tx_cause: assert property ($rose(TX_VALID) |->
      $past(oper && (rx_tlm || rx_sync)))
    else $error("frame offered without trigger");
  chk_cmd_silent: assert property (rx_cmd && !TX_VALID |=> !TX_VALID)
    else $error("command answered by a frame");
  chk_unknown_drop: assert property (rx_unknown && !TX_VALID |=>
      !TX_VALID && unk_cnt == 8'($past(unk_cnt) + 8'h01))
    else $error("unknown code not dropped");
  chk_foreign_quiet: assert property (RX_VALID && !rx_sync && !rx_own |=>
      !CMD_VALID && $stable(unk_cnt))
    else $error("foreign frame acted upon");
  chk_reply_bound: assert property (TX_VALID && !TX_READY && oper &&
      wait_cnt == WAIT_LAST |=> !TX_VALID)
    else $error("reply wait passed its bound");
  chk_tx_ident: assert property (TX_VALID |->
      TX_FRAME.id[6:0] == node_id && TX_FRAME.id[7])
    else $error("transmit identifier is wrong");
  chk_tx_hold: assert property (TX_VALID && !TX_READY && oper &&
      wait_cnt != WAIT_LAST |=> TX_VALID && $stable(TX_FRAME))
    else $error("pending frame changed");
  chk_sync_reply: assert property (s_sync_start |=> s_sync_frame)
    else $error("SYNC did not start channel one reply");
  chk_ack_once: assert property (WB_ACK |=> !WB_ACK)
    else $error("ack held longer than a cycle");
endmodule

//--- design/pdo_slave_pkg.sv
// Constants and frame carriers for the process data slave
// Notes on behaviour
// - Slave never opens an exchange itself
// - Commands run without any reply frame
// - No inhibit time or event timer
// - First data byte carries the command code
// - Telemetry request names registers to return
// - Receive records fixed: count 2, base 200h
// - Transmit records fixed: count 2, base 180h
// - Transmission type of every record is 254
// - Requested data returns in transmit frame
// - Send only on request or SYNC frame
// - No spontaneous frame in request mode
// - Reply delay bounded by a parameter
// - Mapping of transmit data is fixed
// - Remote node control services are ignored
// - SYNC is broadcast identifier 080h
// - Nothing started while pre-operational; pending frame dropped after one cycle
package pdo_slave_pkg;
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          REPLY_LIMIT_NS  = 100000;
  localparam int          REPLY_LIMIT_CYC = REPLY_LIMIT_NS / CLK_PERIOD_NS;
  localparam int          TLM_REGS_DEF    = 16;
  localparam logic [10:0] SYNC_ID         = 11'h080;
  localparam logic [10:0] RX_BASE         = 11'h200;
  localparam logic [10:0] TX_BASE         = 11'h180;
  localparam logic [7:0]  ENTRY_COUNT     = 8'h02;
  localparam logic [7:0]  TRANS_TYPE      = 8'hfe;
  localparam logic [7:0]  CODE_TLM        = 8'h01;
  localparam logic [7:0]  CODE_CMD_LO     = 8'h10;
  localparam logic [7:0]  CODE_CMD_HI     = 8'h1f;
  localparam logic [3:0]  TLM_DLC         = 4'h6;
  localparam logic [7:0]  ADR_CTRL        = 8'h00;
  localparam logic [7:0]  ADR_STATUS      = 8'h04;
  localparam logic [7:0]  ADR_SYNC_SEL    = 8'h08;
  localparam logic [7:0]  ADR_DROPS       = 8'h0c;
  localparam logic [7:0]  ADR_LAST_CMD    = 8'h10;
  localparam logic [7:0]  ADR_RX_REC      = 8'h20;
  localparam logic [7:0]  ADR_TX_REC      = 8'h30;
  localparam logic [7:0]  ADR_TLM         = 8'h40;
  localparam logic        CTRL_RESET      = 1'h0;
  localparam logic [15:0] SYNC_SEL_RESET  = 16'h0100;

  typedef struct packed {
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [63:0] data;
  } can_frame_type;

  typedef struct packed {
    logic [1:0]  chan;
    logic [7:0]  code;
    logic [55:0] args;
  } command_type;
endpackage

//--- test/can_master_model.sv
// Far-side model: CAN controller and network master
`timescale 1ns/100ps
module can_master_model (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [31:0]                  stall,
  input  wire logic                         tx_valid,
  input  wire pdo_slave_pkg::can_frame_type tx_frame,
  output logic                              tx_ready,
  output logic                              rx_valid,
  output pdo_slave_pkg::can_frame_type      rx_frame,
  output int                                tx_count,
  output pdo_slave_pkg::can_frame_type      last_tx
);
  import pdo_slave_pkg::*;
  int wait_cnt;

  // Idle receive side at time zero
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end

  // Only the master opens an exchange; one frame per call
  task automatic send(input logic [10:0] id, input logic [63:0] d);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_frame <= '{id: id, dlc: 4'h8, data: d};
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_frame <= ~rx_frame; // Released lines never keep the last value
  endtask

  // Ready after a chosen stall; no timer of our own paces it
  always @(posedge clk) begin
    if (rst) begin
      tx_ready <= 1'b0;
      wait_cnt <= 0;
      tx_count <= 0;
    end else if (tx_valid && tx_ready) begin
      tx_ready <= 1'b0;
      wait_cnt <= 0;
      tx_count <= tx_count + 1;
      last_tx  <= tx_frame;
    end else if (tx_valid && wait_cnt >= stall) begin
      tx_ready <= 1'b1;
    end else begin
      tx_ready <= 1'b0;
      wait_cnt <= tx_valid ? wait_cnt + 1 : 0;
    end
  end
endmodule

//--- test/testbench.sv
// Self-checking bench for the process data slave
`timescale 1ns/100ps
module testbench;
  import pdo_slave_pkg::*;
  localparam int         RL   = 20;
  localparam logic [6:0] NODE = 7'h25;
  logic          clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, txv, txr, rxv, cmdv;
  logic [7:0]    adr = '0;
  logic [3:0]    sel = '0;
  logic [31:0]   wdat = '0, rdat;
  can_frame_type txf, rxf, last_tx;
  command_type   cmd, got_cmd;
  int            stall = 0, tx_count, n_cmd = 0, n_errors = 0, tests_run = 0;
  logic [15:0]   tlm [16];

  always #4 clk = ~clk;

  pdo_slave #(.TLM_REGS(16), .REPLY_LIMIT(RL)) i_pdo_slave (.CLK(clk), .SYS_RST(rst),
    .NODE_ID(NODE), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK(ack), .RX_VALID(rxv), .RX_FRAME(rxf),
    .TX_READY(txr), .TX_VALID(txv), .TX_FRAME(txf), .CMD_VALID(cmdv), .CMD(cmd));
  can_master_model i_can_master_model (.clk(clk), .rst(rst), .stall(stall), .tx_valid(txv),
    .tx_frame(txf), .tx_ready(txr), .rx_valid(rxv), .rx_frame(rxf), .tx_count(tx_count),
    .last_tx(last_tx));

  // Command pulses are caught where they stand
  always @(posedge clk) if (cmdv === 1'b1) begin
    n_cmd   <= n_cmd + 1;
    got_cmd <= cmd;
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_frame(input can_frame_type got, input can_frame_type exp);
    tests_run++;
    if ({got.id, got.dlc, got.data[47:0]} !== {exp.id, exp.dlc, exp.data[47:0]}) begin
      n_errors++;
      $display("mismatch at %0t: frame %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single cycle: held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) begin
      n_errors++;
      $display("mismatch at %0t: no bus acknowledge", $time);
    end
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  // Settle past the reply bound, then count the frames taken
  task automatic expect_tx(input int n);
    repeat (RL + 10) @(posedge clk);
    chk(tx_count, n);
  endtask
  function automatic can_frame_type reply(input logic [1:0] ch, input logic [7:0] a, b);
    reply.id   = TX_BASE + {ch, 8'h00} + NODE;
    reply.dlc  = TLM_DLC;
    reply.data = {16'h0, tlm[b], tlm[a], b, a};
  endfunction
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  // Main sequence
  initial begin
    for (int i = 0; i < 16; i++) tlm[i] = 16'ha5c0 ^ (16'(i) * 16'h0103);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(ADR_CTRL, 32'h0);
    rd(ADR_SYNC_SEL, 32'h0100);
    rd(ADR_STATUS, {17'h0, NODE, 8'h00});
    for (int i = 0; i < 4; i++) begin
      wr(ADR_RX_REC + 8'(4 * i), 32'hffffffff);
      rd(ADR_RX_REC + 8'(4 * i), {5'h0, RX_BASE + 11'(i * 256) + NODE, 8'hfe, 8'h02});
      rd(ADR_TX_REC + 8'(4 * i), {5'h0, TX_BASE + 11'(i * 256) + NODE, 8'hfe, 8'h02});
    end
    rd(8'hf0, 32'h0);
    for (int i = 0; i < 16; i++) wr(ADR_TLM + 8'(4 * i), {16'h0, tlm[i]});
    rd(ADR_TLM + 8'h3c, {16'h0, tlm[15]});
    // Pre-operational: a request gets no frame
    i_can_master_model.send(RX_BASE + NODE, {40'h0, 8'h02, 8'h01, CODE_TLM});
    expect_tx(0);
    wr(ADR_CTRL, 32'h1);
    // Requests on every channel, the master slower each time
    for (int i = 0; i < 4; i++) begin
      stall <= i;
      i_can_master_model.send(RX_BASE + 11'(i * 256) + NODE, {40'h0, 8'(15 - i), 8'(i), CODE_TLM});
      expect_tx(i + 1);
      chk_frame(last_tx, reply(2'(i), 8'(i), 8'(15 - i)));
    end
    wr(ADR_SYNC_SEL, 32'h0907);
    i_can_master_model.send(SYNC_ID, 64'h0);
    expect_tx(5);
    chk_frame(last_tx, reply(2'd0, 8'h07, 8'h09));
    // Every command code, with no reply frame
    for (int i = 0; i < 16; i++) begin
      i_can_master_model.send(RX_BASE + 11'((i % 4) * 256) + NODE,
                              {56'(i * 32'h01020304), 8'(8'h10 + i)});
      repeat (2) @(posedge clk);
      chk(n_cmd, i + 1);
      chk(got_cmd, {2'(i % 4), 8'(8'h10 + i), 56'(i * 32'h01020304)});
    end
    expect_tx(5);
    rd(ADR_LAST_CMD, {22'h0, 2'd3, 8'h1f});
    // Unknown code counted, never answered; foreign node and node control ignored
    i_can_master_model.send(RX_BASE + NODE, {56'h0, 8'h05});
    i_can_master_model.send(RX_BASE + NODE + 11'h1, {40'h0, 8'h02, 8'h01, CODE_TLM});
    i_can_master_model.send(11'h000, {48'h0, 1'b0, NODE, 8'h02});
    expect_tx(5);
    chk(n_cmd, 16);
    rd(ADR_CTRL, 32'h1);
    rd(ADR_DROPS, 32'h1);
    // Master never takes the reply: withdrawn within the bound
    stall <= 100;
    i_can_master_model.send(RX_BASE + 11'h300 + NODE, {40'h0, 8'h01, 8'h00, CODE_TLM});
    expect_tx(5);
    chk(txv, 1'b0);
    rd(ADR_DROPS, 32'h0101);
    // Out-of-range index and a trigger while busy: counted, never answered
    i_can_master_model.send(RX_BASE + NODE, {40'h0, 8'h10, 8'h00, CODE_TLM});
    i_can_master_model.send(SYNC_ID, 64'h0);
    i_can_master_model.send(SYNC_ID, 64'h0);
    expect_tx(5);
    rd(ADR_DROPS, 32'h0302);
    // Mid-run reset returns the node to its pre-operational defaults
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(ADR_CTRL, 32'h0);
    rd(ADR_SYNC_SEL, 32'h0100);
    rd(ADR_DROPS, 32'h0);
    // Leaving operation withdraws a pending frame long before the bound
    wr(ADR_CTRL, 32'h1);
    i_can_master_model.send(RX_BASE + NODE, {40'h0, 8'h01, 8'h00, CODE_TLM});
    wr(ADR_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk(txv, 1'b0);
    end_sim();
  end
endmodule
